//--- rtl/wit_timer.sv
// Purpose: 8-bit watchdog / interval timer with password-protected writes
// Assumes: bus strobes are synchronous single-cycle pulses; rstn synced
// Notes:   internal reset request feeds the chip reset controller outside
`timescale 1ns/1ps
module wit_timer
  import wit_pkg::*;
(
  input  wire logic     clk,              // system clock, 25 MHz
  input  wire logic     rstn,             // synchronous reset from the reset pin, active low
  input  wire logic     standby,          // software standby entry level
  input  wire wit_bus_t bus,              // register access request
  output logic [7:0]    rdata,            // registered read data
  output logic          interval_irq,     // interval interrupt request level
  output logic          chip_reset_req,   // internal reset request, 518 states
  output logic          external_reset_out_n // external reset pin, active low
);
  logic [7:0]  watchdog_up_count_r, cnt_nxt;
  wit_tcs_t    tcs_r, tcs_nxt;
  logic        wd_status_r, wd_status_nxt;
  logic        out_en_r, out_en_nxt;
  logic [WIT_RST_CNT_W-1:0] fire_age_r, fire_age_nxt;
  logic        fire_oe_r, fire_oe_nxt;
  logic        ovf_seen_r, ovf_seen_nxt;
  logic [WIT_RST_CNT_W-1:0] irst_r, irst_nxt;
  logic [WIT_RST_CNT_W-1:0] xrst_r, xrst_nxt;
  logic [7:0]  rdata_nxt;
  logic        tick, ovf_ev, wd_fire;
  logic        wr_tcs, wr_cnt, wr_rclr, wr_roe;
  logic [7:0]  tcs_byte, rcs_byte;

  wit_prescaler u_pre (
    .clk  (clk),
    .rstn (rstn),
    .cks  (tcs_r.cks),
    .tick (tick)
  );

  function automatic logic word_wr(input wit_bus_t b, input logic [15:0] a,
                                   input logic [7:0] key);
    word_wr = b.wr && b.word && (b.addr == a) && (b.wdata[15:8] == key);
  endfunction : word_wr

  always_comb begin
    wr_cnt  = word_wr(bus, WIT_ADDR_TCS_W, WIT_KEY_CNT);
    wr_tcs  = word_wr(bus, WIT_ADDR_TCS_W, WIT_KEY_TCS);
    wr_rclr = word_wr(bus, WIT_ADDR_RCS_W, WIT_KEY_TCS)
              && (bus.wdata[7:0] == WIT_RCS_CLR_DATA);
    wr_roe  = word_wr(bus, WIT_ADDR_RCS_W, WIT_KEY_CNT);
    ovf_ev  = tcs_r.run && tick && !wr_cnt
              && (watchdog_up_count_r == 8'hff);
    wd_fire = ovf_ev && tcs_r.mode;
    tcs_byte = {tcs_r.ovf, tcs_r.mode, tcs_r.run, 2'b00, tcs_r.cks} | WIT_TCS_FIXED1;
    rcs_byte = {wd_status_r, out_en_r, 6'h00} | WIT_RCS_FIXED1;
  end

  // counter
  always_comb begin
    cnt_nxt = watchdog_up_count_r;
    if (wr_cnt)            cnt_nxt = bus.wdata[7:0];
    else if (tcs_r.run && tick) cnt_nxt = watchdog_up_count_r + 8'h01;
    if (!tcs_nxt.run)      cnt_nxt = WIT_CNT_RESET;
  end

  // control/status; flag clear needs a prior read of the flag as one
  always_comb begin
    tcs_nxt      = tcs_r;
    ovf_seen_nxt = ovf_seen_r;
    if (bus.rd && bus.addr == WIT_ADDR_TCS_R && tcs_r.ovf) ovf_seen_nxt = 1'b1;
    if (wr_tcs) begin
      tcs_nxt.mode = bus.wdata[WIT_BIT_MODE];
      tcs_nxt.run  = bus.wdata[WIT_BIT_RUN];
      tcs_nxt.cks  = bus.wdata[2:0];
      if (!bus.wdata[WIT_BIT_OVERFLOW] && ovf_seen_r) begin
        tcs_nxt.ovf  = 1'b0;
        ovf_seen_nxt = 1'b0;
      end
    end
    if (ovf_ev) tcs_nxt.ovf = 1'b1;
    if (standby) begin
      tcs_nxt.ovf  = 1'b0;
      tcs_nxt.mode = 1'b0;
      tcs_nxt.run  = 1'b0;
      ovf_seen_nxt = 1'b0;
    end
  end

  // reset status; reset pin wins since rstn branch comes first below
  always_comb begin
    wd_status_nxt = wd_status_r;
    out_en_nxt    = out_en_r;
    if (wr_rclr) wd_status_nxt = 1'b0;
    if (wr_roe)  out_en_nxt    = bus.wdata[WIT_BIT_OUT_EN];
    if (wd_fire) wd_status_nxt = 1'b1;
  end

  // reset pulse timers
  always_comb begin
    irst_nxt = (irst_r != '0) ? irst_r - 1'b1 : irst_r;
    xrst_nxt = (xrst_r != '0) ? xrst_r - 1'b1 : xrst_r;
    if (wd_fire) begin
      irst_nxt = WIT_RST_CNT_W'(WIT_INT_RST_STATES);
      xrst_nxt = out_en_r ? WIT_RST_CNT_W'(WIT_EXT_RST_STATES) : '0;
    end
  end

  always_comb begin
    rdata_nxt = rdata;
    if (bus.rd) begin
      case (bus.addr)
        WIT_ADDR_TCS_R: rdata_nxt = tcs_byte;
        WIT_ADDR_CNT_R: rdata_nxt = watchdog_up_count_r;
        WIT_ADDR_RCS_R: rdata_nxt = rcs_byte;
        default:        rdata_nxt = 8'h00;
      endcase
    end
  end

  // the watchdog's own reset request is not fed back here, so the reset
  // status bits survive it; the chip-level reset clears the rest
  always_ff @(posedge clk) begin
    if (!rstn) begin
      watchdog_up_count_r <= WIT_CNT_RESET;
      tcs_r      <= '0;
      ovf_seen_r <= 1'b0;
      wd_status_r <= 1'b0;
      out_en_r   <= 1'b0;
      irst_r     <= '0;
      xrst_r     <= '0;
      rdata      <= 8'h00;
    end else begin
      watchdog_up_count_r <= cnt_nxt;
      tcs_r      <= tcs_nxt;
      ovf_seen_r <= ovf_seen_nxt;
      wd_status_r <= wd_status_nxt;
      out_en_r   <= out_en_nxt;
      irst_r     <= irst_nxt;
      xrst_r     <= xrst_nxt;
      rdata      <= rdata_nxt;
    end
  end

  always_comb begin
    interval_irq         = tcs_r.ovf && !tcs_r.mode;
    chip_reset_req       = (irst_r != '0);
    external_reset_out_n = (xrst_r == '0);
  end

  property p_ovf_sets;
    @(posedge clk) disable iff (!rstn)
      (ovf_ev && !standby) |=> tcs_r.ovf;
  endproperty
  a_ovf_sets: assert property (p_ovf_sets) else $error("overflow flag not set");

  property p_run_off_zero;
    @(posedge clk) disable iff (!rstn)
      !tcs_r.run |-> watchdog_up_count_r == 8'h00;
  endproperty
  a_run_off_zero: assert property (p_run_off_zero) else $error("count not zero");

  property p_byte_ignored;
    @(posedge clk) disable iff (!rstn)
      (bus.wr && !bus.word && !tick && !standby) |=> $stable(watchdog_up_count_r);
  endproperty
  a_byte_ignored: assert property (p_byte_ignored) else $error("byte write took effect");

  property p_cnt_write;
    @(posedge clk) disable iff (!rstn)
      (wr_cnt && tcs_nxt.run) |=> watchdog_up_count_r == $past(bus.wdata[7:0]);
  endproperty
  a_cnt_write: assert property (p_cnt_write) else $error("count write lost");

  property p_status_set;
    @(posedge clk) disable iff (!rstn)
      wd_fire |=> wd_status_r && chip_reset_req;
  endproperty
  a_status_set: assert property (p_status_set) else $error("watchdog status not set");

  property p_ext_len;
    @(posedge clk) disable iff (!rstn)
      (wd_fire && out_en_r) |=> !external_reset_out_n [*8];
  endproperty
  a_ext_len: assert property (p_ext_len) else $error("external reset too short");

  property p_ext_gated;
    @(posedge clk) disable iff (!rstn)
      (wd_fire && !out_en_r) |=> external_reset_out_n;
  endproperty
  a_ext_gated: assert property (p_ext_gated) else $error("reset output not gated");

  property p_int_end;
    @(posedge clk) disable iff (!rstn)
      $rose(chip_reset_req) |-> chip_reset_req [*8] ##[1:600] !chip_reset_req;
  endproperty
  a_int_end: assert property (p_int_end) else $error("internal reset length wrong");

  property p_irq_mode;
    @(posedge clk) disable iff (!rstn)
      (ovf_ev && !tcs_r.mode && !wr_tcs && !standby) |=> interval_irq;
  endproperty
  a_irq_mode: assert property (p_irq_mode) else $error("interrupt not raised");

  // checker helper: cycles since the last watchdog fire, saturating, so the
  // pulse lengths are checked by a count kept apart from the pulse timers
  always_comb begin
    fire_age_nxt = fire_age_r;
    fire_oe_nxt  = fire_oe_r;
    if (wd_fire) begin
      fire_age_nxt = '0;
      fire_oe_nxt  = out_en_r;
    end else if (fire_age_r != '1) begin
      fire_age_nxt = fire_age_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      fire_age_r <= '1;
      fire_oe_r  <= 1'b0;
    end else begin
      fire_age_r <= fire_age_nxt;
      fire_oe_r  <= fire_oe_nxt;
    end
  end

  property p_int_on;
    @(posedge clk) disable iff (!rstn)
      (fire_age_r < WIT_RST_CNT_W'(WIT_INT_RST_STATES)) |-> chip_reset_req;
  endproperty
  a_int_on: assert property (p_int_on) else $error("internal reset ended early");

  property p_int_off;
    @(posedge clk) disable iff (!rstn)
      (fire_age_r >= WIT_RST_CNT_W'(WIT_INT_RST_STATES)) |-> !chip_reset_req;
  endproperty
  a_int_off: assert property (p_int_off) else $error("internal reset too long");

  property p_ext_on;
    @(posedge clk) disable iff (!rstn)
      (fire_age_r < WIT_RST_CNT_W'(WIT_EXT_RST_STATES) && fire_oe_r)
        |-> !external_reset_out_n;
  endproperty
  a_ext_on: assert property (p_ext_on) else $error("external reset ended early");

  property p_ext_off;
    @(posedge clk) disable iff (!rstn)
      (fire_age_r < WIT_RST_CNT_W'(WIT_EXT_RST_STATES) && !fire_oe_r)
        |-> external_reset_out_n;
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("external reset not gated");

  property p_ext_idle;
    @(posedge clk) disable iff (!rstn)
      (fire_age_r >= WIT_RST_CNT_W'(WIT_EXT_RST_STATES)) |-> external_reset_out_n;
  endproperty
  a_ext_idle: assert property (p_ext_idle) else $error("external reset not idle");

  property p_pin_clears;
    @(posedge clk)
      !rstn |=> (!wd_status_r && !out_en_r);
  endproperty
  a_pin_clears: assert property (p_pin_clears) else $error("pin reset kept status");

  property p_status_keep;
    @(posedge clk) disable iff (!rstn)
      (wd_status_r && !wr_rclr) |=> wd_status_r;
  endproperty
  a_status_keep: assert property (p_status_keep) else $error("watchdog status lost");

  property p_status_clear;
    @(posedge clk) disable iff (!rstn)
      (wr_rclr && !wd_fire) |=> !wd_status_r;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status not cleared");

  property p_out_en_wr;
    @(posedge clk) disable iff (!rstn)
      wr_roe |=> out_en_r == $past(bus.wdata[WIT_BIT_OUT_EN]);
  endproperty
  a_out_en_wr: assert property (p_out_en_wr) else $error("output enable not written");

  property p_flag_hold;
    @(posedge clk) disable iff (!rstn)
      (tcs_r.ovf && !(wr_tcs && ovf_seen_r) && !standby) |=> tcs_r.ovf;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("overflow flag lost");

  property p_standby;
    @(posedge clk) disable iff (!rstn)
      (standby && !wr_tcs) |=> (!tcs_r.ovf && !tcs_r.mode && !tcs_r.run && $stable(tcs_r.cks));
  endproperty
  a_standby: assert property (p_standby) else $error("standby clear wrong");

  property p_read_cnt;
    @(posedge clk) disable iff (!rstn)
      (bus.rd && bus.addr == WIT_ADDR_CNT_R) |=> rdata == $past(watchdog_up_count_r);
  endproperty
  a_read_cnt: assert property (p_read_cnt) else $error("count read wrong");

  property p_up_step;
    @(posedge clk) disable iff (!rstn)
      (tcs_r.run && tick && !wr_cnt && tcs_nxt.run)
        |=> watchdog_up_count_r == 8'($past(watchdog_up_count_r) + 8'h01);
  endproperty
  a_up_step: assert property (p_up_step) else $error("count did not advance");
endmodule : wit_timer

//--- rtl/wit_pkg.sv
// Purpose: shared constants and types for the watchdog/interval timer
// Assumes: 16-bit internal register port, byte or word accesses, 25 MHz clock
// Notes:   addresses are the low 16 bits of the internal address space
package wit_pkg;
  localparam logic [15:0] WIT_ADDR_TCS_W   = 16'hffa8; // word write: count / control-status
  localparam logic [15:0] WIT_ADDR_RCS_W   = 16'hffaa; // word write: reset control/status
  localparam logic [15:0] WIT_ADDR_TCS_R   = 16'hffa8; // byte read: control/status
  localparam logic [15:0] WIT_ADDR_CNT_R   = 16'hffa9; // byte read: up count
  localparam logic [15:0] WIT_ADDR_RCS_R   = 16'hffab; // byte read: reset control/status
  localparam logic [7:0]  WIT_KEY_CNT      = 8'h5a;
  localparam logic [7:0]  WIT_KEY_TCS      = 8'ha5;
  localparam logic [7:0]  WIT_RCS_CLR_DATA = 8'h00;
  localparam logic [7:0]  WIT_TCS_RESET    = 8'h18;
  localparam logic [7:0]  WIT_CNT_RESET    = 8'h00;
  localparam logic [7:0]  WIT_RCS_RESET    = 8'h3f;
  localparam logic [7:0]  WIT_TCS_FIXED1   = 8'h18;  // bits 4,3 read as one
  localparam logic [7:0]  WIT_RCS_FIXED1   = 8'h3f;  // bits 5..0 read as one
  localparam int          WIT_BIT_OVERFLOW = 7;
  localparam int          WIT_BIT_MODE     = 6;
  localparam int          WIT_BIT_RUN      = 5;
  localparam int          WIT_BIT_WD_STAT  = 7;
  localparam int          WIT_BIT_OUT_EN   = 6;
  localparam int          WIT_PRE_W        = 12;
  localparam int          WIT_INT_RST_STATES = 518;
  localparam int          WIT_EXT_RST_STATES = 132;
  localparam int          WIT_RST_CNT_W    = 10;

  typedef struct packed {
    logic        wr;      // write strobe, one cycle
    logic        rd;      // read strobe, one cycle
    logic        word;    // 1: 16-bit access, 0: byte access
    logic [15:0] addr;
    logic [15:0] wdata;
  } wit_bus_t;

  typedef struct packed {
    logic       ovf;
    logic       mode;
    logic       run;
    logic [2:0] cks;
  } wit_tcs_t;
endpackage : wit_pkg

//--- rtl/wit_prescaler.sv
// Purpose: free-running system clock divider with eight selectable taps
// Assumes: clk is the system clock
// Notes:   pulse is one cycle wide at each falling edge of the chosen tap
`timescale 1ns/1ps
module wit_prescaler
  import wit_pkg::*;
(
  input  wire logic       clk,    // system clock
  input  wire logic       rstn,   // synchronous reset, active low
  input  wire logic [2:0] cks,    // tap select
  output logic            tick    // one-cycle count pulse
);
  logic [WIT_PRE_W-1:0] div_r, div_nxt;

  // tap bit index: divide by 2^(idx+1)
  function automatic int tap_idx(input logic [2:0] s);
    case (s)
      3'h0:    tap_idx = 0;
      3'h1:    tap_idx = 4;
      3'h2:    tap_idx = 5;
      3'h3:    tap_idx = 6;
      3'h4:    tap_idx = 7;
      3'h5:    tap_idx = 8;
      3'h6:    tap_idx = 10;
      default: tap_idx = 11;
    endcase
  endfunction : tap_idx

  always_comb begin
    div_nxt = div_r + 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rstn) div_r <= '0;
    else       div_r <= div_nxt;
  end

  // low bits all ones means the chosen tap falls on the next edge
  always_comb begin
    tick = &(div_r | ~((12'h001 << (tap_idx(cks) + 1)) - 12'h001));
  end
endmodule : wit_prescaler

//--- sim/test_wit_timer.sv
// Purpose: self-checking bench for the watchdog / interval timer
// Assumes: bus strobes taken on the rising edge, inputs driven 1 ns after it
// Notes:   read data is matched against a queue of expected bytes
`timescale 1ns/1ps
module test_wit_timer;
  import wit_pkg::*;
  logic       clk;
  logic       rstn;
  logic       standby;
  wit_bus_t   bus_s;
  logic [7:0] rdata;
  logic       irq;
  logic       crst;
  logic       xrst_n;
  logic [7:0] exp_q[$];
  logic       rd_d;
  logic [7:0] seed;
  int         n_mismatch;
  int         n_checks;
  int         crst_len;
  int         crst_run;
  int         xrst_len;
  int         xrst_run;
  int         divs[8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};

  wit_timer dut (
    .clk                  (clk),
    .rstn                 (rstn),
    .standby              (standby),
    .bus                  (bus_s),
    .rdata                (rdata),
    .interval_irq         (irq),
    .chip_reset_req       (crst),
    .external_reset_out_n (xrst_n)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // strobes stay up between back-to-back calls; idle lowers them
  task automatic wr(input logic word, input logic [15:0] addr, input logic [15:0] data);
    bus_s = '{wr: 1'b1, rd: 1'b0, word: word, addr: addr, wdata: data};
    @(posedge clk);
    #1;
  endtask : wr

  task automatic rd(input logic [15:0] addr, input logic [7:0] exp);
    exp_q.push_back(exp);
    bus_s = '{wr: 1'b0, rd: 1'b1, word: 1'b0, addr: addr, wdata: 16'h0000};
    @(posedge clk);
    #1;
  endtask : rd

  task automatic idle;
    bus_s.wr = 1'b0;
    bus_s.rd = 1'b0;
  endtask : idle

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  always @(posedge clk) rd_d <= bus_s.rd;

  always @(negedge clk) begin
    if (rd_d && exp_q.size() > 0) begin
      chk("rdata", {8'h00, exp_q.pop_front()}, {8'h00, rdata});
    end
  end

  // pulse widths in clock cycles, stored when each pulse ends
  // sampled on the falling edge, where the pulses are settled
  always @(negedge clk) begin
    if (crst === 1'b1) crst_run++;
    else if (crst_run != 0) begin
      crst_len = crst_run;
      crst_run = 0;
    end
    if (xrst_n === 1'b0) xrst_run++;
    else if (xrst_run != 0) begin
      xrst_len = xrst_run;
      xrst_run = 0;
    end
  end

  initial begin
    #2400000;
    n_mismatch++;
    summarize();
  end

  initial begin
    rstn = 1'b0;
    standby = 1'b0;
    bus_s = '0;
    seed = 8'h3c;
    repeat (8) @(posedge clk);
    #1 rstn = 1'b1;
    rd(WIT_ADDR_TCS_R, WIT_TCS_RESET);
    rd(WIT_ADDR_CNT_R, WIT_CNT_RESET);
    rd(WIT_ADDR_RCS_R, WIT_RCS_RESET);
    rd(16'hffac, 8'h00);
    wr(1'b0, WIT_ADDR_TCS_W, 16'h00e0);
    wr(1'b1, WIT_ADDR_TCS_W, 16'h12e0);
    rd(WIT_ADDR_TCS_R, 8'h18);
    for (int c = 0; c < 8; c++) begin
      wr(1'b1, WIT_ADDR_TCS_W, {WIT_KEY_TCS, 8'h20 | 8'(c)});
      wr(1'b1, WIT_ADDR_TCS_W, {WIT_KEY_CNT, 8'h00});
      idle();
      cyc(4 * divs[c]);
      rd(WIT_ADDR_CNT_R, 8'h04);
      wr(1'b1, WIT_ADDR_TCS_W, {WIT_KEY_TCS, 8'(c)});
      rd(WIT_ADDR_CNT_R, 8'h00);
    end
    wr(1'b1, WIT_ADDR_TCS_W, {WIT_KEY_TCS, 8'h27});
    repeat (4) begin
      seed = lfsr(seed);
      wr(1'b1, WIT_ADDR_TCS_W, {WIT_KEY_CNT, seed});
      rd(WIT_ADDR_CNT_R, seed);
    end
    wr(1'b1, WIT_ADDR_TCS_W, {WIT_KEY_TCS, 8'h20});
    wr(1'b1, WIT_ADDR_TCS_W, {WIT_KEY_CNT, 8'hfe});
    idle();
    cyc(10);
    chk("irq", 16'h0001, {15'h0, irq});
    chk("chip_reset", 16'h0000, {15'h0, crst});
    // clearing before the flag was read must not take
    wr(1'b1, WIT_ADDR_TCS_W, {WIT_KEY_TCS, 8'h20});
    rd(WIT_ADDR_TCS_R, 8'hb8);
    wr(1'b1, WIT_ADDR_TCS_W, {WIT_KEY_TCS, 8'h20});
    rd(WIT_ADDR_TCS_R, 8'h38);
    idle();
    cyc(2);
    chk("irq", 16'h0000, {15'h0, irq});
    wr(1'b1, WIT_ADDR_RCS_W, {WIT_KEY_CNT, 8'h40});
    rd(WIT_ADDR_RCS_R, 8'h7f);
    for (int k = 0; k < 2; k++) begin
      crst_len = 0;
      xrst_len = 0;
      wr(1'b1, WIT_ADDR_TCS_W, {WIT_KEY_TCS, 8'h67});
      wr(1'b1, WIT_ADDR_TCS_W, {WIT_KEY_CNT, 8'hff});
      idle();
      cyc(5000);
      chk("reset_len", 16'(WIT_INT_RST_STATES), 16'(crst_len));
      chk("external_reset_out_n_len", k ? 16'h0 : 16'(WIT_EXT_RST_STATES), 16'(xrst_len));
      rd(WIT_ADDR_RCS_R, k ? 8'hbf : 8'hff);
      wr(1'b1, WIT_ADDR_RCS_W, {WIT_KEY_TCS, WIT_RCS_CLR_DATA});
      wr(1'b1, WIT_ADDR_RCS_W, {WIT_KEY_CNT, 8'h00});
      rd(WIT_ADDR_RCS_R, 8'h3f);
    end
    idle();
    chk("external_reset_out_n", 16'h0001, {15'h0, xrst_n});
    standby = 1'b1;
    cyc(1);
    standby = 1'b0;
    rd(WIT_ADDR_TCS_R, 8'h1f);
    wr(1'b1, WIT_ADDR_RCS_W, {WIT_KEY_CNT, 8'h40});
    idle();
    rstn = 1'b0;
    cyc(1);
    rstn = 1'b1;
    rd(WIT_ADDR_RCS_R, WIT_RCS_RESET);
    rd(WIT_ADDR_TCS_R, WIT_TCS_RESET);
    idle();
    cyc(2);
    summarize();
  end
endmodule : test_wit_timer
